// File: imc_top.v
// imc_top.v: interface mode register with block fill, standby and offset measure
// assumes one ahb-lite master, hclk as master clock, frame_pulse once per frame
// assumes frame_edge_seen with frame_edge_delay come from the frame evaluator
// assumes a sweep of CM_DEPTH words fits well inside one frame
// hsize is ignored: every register is one aligned word
// software that breaks or gets undefined fill or measure results
//
// The register addresses and register access over AHB-Lite are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "imc_defines.vh"

module imc_top #(
  parameter CM_DEPTH = 2048,
  parameter CM_AW    = 11
) (
  // clock and reset
  input  wire                    hclk,
  input  wire                    hresetn,
  // ahb-lite slave
  input  wire                    hsel,
  input  wire [31:0]             haddr,
  input  wire [1:0]              htrans,
  input  wire                    hwrite,
  input  wire [2:0]              hsize,
  input  wire [31:0]             hwdata,
  input  wire                    hready,
  output reg  [31:0]             hrdata,
  output reg                     hreadyout,
  output reg                     hresp,
  // frame timing and pins
  input  wire                    frame_pulse,
  input  wire                    output_drive_enable,
  input  wire                    frame_edge_seen,
  input  wire [11:0]             frame_edge_delay,
  // connection memory write port
  output reg                     cm_we,
  output reg  [CM_AW-1:0]        cm_addr,
  output reg  [`IMC_CM_W-1:0]    cm_wdata,
  // serial output control
  output reg                     serial_out_oe_n,
  output reg  [1:0]              serial_rate_sel,
  output reg                     rate_reserved
);

  // block fill engine states
  localparam ST_IDLE = 2'h0;
  localparam ST_WAIT = 2'h1;
  localparam ST_FILL = 2'h2;
  localparam ST_DONE = 2'h3;

  // state held across cycles
  reg  [`IMC_MODE_W-1:0]   mode_reg;
  reg                      block_fill_allow_reg;
  reg  [1:0]               fill_state_reg;
  reg  [CM_AW-1:0]         fill_idx_reg;
  reg                      meas_busy_reg;
  reg                      offset_measure_done_reg;
  reg  [`IMC_MEAS_W-1:0]   meas_val_reg;
  reg                      wr_pend_reg;
  reg                      rd_pend_reg;
  reg  [`IMC_ADDR_W-1:0]   addr_reg;
  reg                      meas_go_d_reg;
  reg                      fill_go_d_reg;

  // field taps, bus decode and next values
  wire                     block_fill_go;
  wire                     offset_measure_go;
  wire                     output_standby_release;
  wire [4:0]               block_fill_value;
  wire                     acc;
  wire                     wr_mode;
  wire                     wr_ctrl;
  wire [`IMC_MODE_W-1:0]   wdata_mode;
  wire                     fill_abort;
  wire                     fill_finish;
  wire                     fill_start;
  reg  [31:0]              rdata_next;
  reg  [`IMC_MODE_W-1:0]   mode_next;
  reg                      allow_next;
  reg  [1:0]               fill_state_next;
  wire                     fill_last;
  wire                     fill_busy;
  wire                     meas_rise;
  wire                     meas_fall;
  wire [1:0]               rate_field;

  assign block_fill_go          = mode_reg[`IMC_FILL_GO_BIT];
  assign offset_measure_go      = mode_reg[`IMC_MEAS_GO_BIT];
  assign output_standby_release = mode_reg[`IMC_STBY_BIT];
  assign block_fill_value       = mode_reg[`IMC_FILL_VAL_MSB:`IMC_FILL_VAL_LSB];
  assign acc        = hsel & hready & htrans[`IMC_HTRANS_ACT_BIT];
  assign wr_mode    = wr_pend_reg & (addr_reg == `IMC_ADDR_MODE);
  assign wr_ctrl    = wr_pend_reg & (addr_reg == `IMC_ADDR_CTRL);
  assign wdata_mode = hwdata[`IMC_MODE_W-1:0];
  // abort when go or allow is dropped during the run
  assign fill_abort = (fill_state_reg != ST_IDLE) &
                      ((wr_mode & ~wdata_mode[`IMC_FILL_GO_BIT]) |
                       (wr_ctrl & ~hwdata[`IMC_ALLOW_BIT]));
  // rising edge of go, gated by allow
  assign fill_start = (fill_state_reg == ST_IDLE) & block_fill_go & ~fill_go_d_reg &
                      block_fill_allow_reg;
  assign fill_finish = (fill_state_reg == ST_DONE) & ~fill_abort;
  assign fill_busy   = (fill_state_reg != ST_IDLE);
  // last word of the sweep
  assign fill_last   = (fill_idx_reg == CM_DEPTH[CM_AW-1:0] - {{(CM_AW-1){1'b0}}, 1'b1});
  // go bit edges for the measurement
  assign meas_rise   = offset_measure_go & ~meas_go_d_reg;
  assign meas_fall   = ~offset_measure_go & meas_go_d_reg;
  assign rate_field  = mode_reg[`IMC_RATE_MSB:`IMC_RATE_LSB];

  // ahb-lite address phase capture; zero wait states
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_reg <= 1'b0;
      rd_pend_reg <= 1'b0;
      addr_reg    <= {`IMC_ADDR_W{1'b0}};
      hreadyout   <= 1'b1;
      hresp       <= 1'b0;
      hrdata      <= 32'h0000_0000;
    end
    else
    begin
      wr_pend_reg <= acc & hwrite;
      rd_pend_reg <= acc & ~hwrite;
      addr_reg    <= haddr[`IMC_ADDR_W-1:0];
      hreadyout   <= 1'b1;
      hresp       <= 1'b0;
      // read data captured in the address phase, stands in the data phase
      if (acc & ~hwrite)
      begin
        hrdata <= rdata_next;
      end
    end
  end

  // read mux, decoded in the address phase
  always @*
  begin
    rdata_next = 32'h0000_0000;
    case (haddr[`IMC_ADDR_W-1:0])
      `IMC_ADDR_MODE:
      begin
        rdata_next = {16'h0000, mode_reg};
      end
      `IMC_ADDR_CTRL:
      begin
        rdata_next = {31'h0000_0000, block_fill_allow_reg};
      end
      `IMC_ADDR_STATUS:
      begin
        rdata_next = {29'h0000_0000, meas_busy_reg, fill_busy, offset_measure_done_reg};
      end
      `IMC_ADDR_MEAS:
      begin
        rdata_next = {19'h0_0000, offset_measure_done_reg, meas_val_reg};
      end
      default:
      begin
        rdata_next = 32'h0000_0000;
      end
    endcase
  end

  // next mode value: software write, go self-clear on finish or abort
  always @*
  begin
    mode_next  = mode_reg;
    allow_next = block_fill_allow_reg;
    if (wr_mode)
    begin
      mode_next = wdata_mode;
    end
    else if (fill_finish | (fill_abort & wr_ctrl))
    begin
      mode_next[`IMC_FILL_GO_BIT] = 1'b0;
    end
    if (wr_ctrl)
    begin
      allow_next = hwdata[`IMC_ALLOW_BIT];
    end
  end

  // mode and control registers
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      mode_reg             <= `IMC_MODE_RST;
      block_fill_allow_reg <= 1'b0;
    end
    else
    begin
      mode_reg             <= mode_next;
      block_fill_allow_reg <= allow_next;
    end
  end

  // block fill sequencing: wait a frame edge, sweep memory, done by second frame
  always @*
  begin
    fill_state_next = fill_state_reg;
    if (fill_abort)
    begin
      fill_state_next = ST_IDLE;
    end
    else
    begin
      case (fill_state_reg)
        ST_IDLE:
        begin
          if (fill_start)
          begin
            fill_state_next = ST_WAIT;
          end
        end
        ST_WAIT:
        begin
          if (frame_pulse)
          begin
            fill_state_next = ST_FILL;
          end
        end
        ST_FILL:
        begin
          if (fill_last)
          begin
            fill_state_next = ST_DONE;
          end
        end
        ST_DONE:
        begin
          fill_state_next = ST_IDLE;
        end
        default:
        begin
          fill_state_next = ST_IDLE;
        end
      endcase
    end
  end

  // block fill datapath: one connection memory word per cycle while sweeping
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      fill_state_reg <= ST_IDLE;
      fill_idx_reg   <= {CM_AW{1'b0}};
      fill_go_d_reg  <= 1'b0;
      cm_we          <= 1'b0;
      cm_addr        <= {CM_AW{1'b0}};
      cm_wdata       <= {`IMC_CM_W{1'b0}};
    end
    else
    begin
      fill_state_reg <= fill_state_next;
      fill_go_d_reg  <= block_fill_go;
      cm_we          <= 1'b0;
      if ((fill_state_reg == ST_WAIT) & ~fill_abort)
      begin
        fill_idx_reg <= {CM_AW{1'b0}};
      end
      if ((fill_state_reg == ST_FILL) & ~fill_abort)
      begin
        cm_we        <= 1'b1;
        cm_addr      <= fill_idx_reg;
        cm_wdata     <= {block_fill_value, `IMC_CM_LOW_ZERO};
        fill_idx_reg <= fill_idx_reg + {{(CM_AW-1){1'b0}}, 1'b1};
      end
    end
  end

  // offset measurement: start on rising go, stop on done, clear on falling go
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      meas_go_d_reg           <= 1'b0;
      meas_busy_reg           <= 1'b0;
      offset_measure_done_reg <= 1'b0;
      meas_val_reg            <= `IMC_MEAS_RST;
    end
    else
    begin
      meas_go_d_reg <= offset_measure_go;
      if (meas_fall)
      begin
        meas_busy_reg           <= 1'b0;
        offset_measure_done_reg <= 1'b0;
        meas_val_reg            <= `IMC_MEAS_RST;
      end
      else if (meas_rise)
      begin
        meas_busy_reg <= 1'b1;
      end
      else if (meas_busy_reg & frame_edge_seen)
      begin
        meas_busy_reg           <= 1'b0;
        offset_measure_done_reg <= 1'b1;
        meas_val_reg            <= frame_edge_delay;
      end
    end
  end

  // output drive gating and rate selection
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      serial_out_oe_n <= 1'b1;
      serial_rate_sel <= `IMC_RATE_2M;
      rate_reserved   <= 1'b0;
    end
    else
    begin
      serial_out_oe_n <= ~(output_drive_enable | output_standby_release);
      serial_rate_sel <= rate_field;
      rate_reserved   <= (rate_field == `IMC_RATE_RSV);
    end
  end

endmodule // imc_top

`default_nettype wire

// File: imc_defines.vh
// imc_defines.vh: constants for the interface mode control block
// assumes inclusion by imc_top.v only
`ifndef IMC_DEFINES_VH
`define IMC_DEFINES_VH

// register byte addresses on the ahb-lite window
`define IMC_ADDR_MODE        8'h00
`define IMC_ADDR_CTRL        8'h04
`define IMC_ADDR_STATUS      8'h08
`define IMC_ADDR_MEAS        8'h0c
`define IMC_ADDR_W           8

// interface mode register fields
`define IMC_RATE_LSB         0
`define IMC_RATE_MSB         1
`define IMC_MEAS_GO_BIT      2
`define IMC_STBY_BIT         3
`define IMC_FILL_GO_BIT      4
`define IMC_FILL_VAL_LSB     5
`define IMC_FILL_VAL_MSB     9
`define IMC_MODE_W           16
`define IMC_MODE_RST         16'h0000

// control register: fill allow in bit 0
`define IMC_ALLOW_BIT        0

// connection memory word layout
`define IMC_CM_W             16
`define IMC_CM_LOW_ZERO      11'h000

// rate codes
`define IMC_RATE_2M          2'h0
`define IMC_RATE_4M          2'h1
`define IMC_RATE_8M          2'h2
`define IMC_RATE_RSV         2'h3

// measured delay width
`define IMC_MEAS_W           12
`define IMC_MEAS_RST         12'h000

// htrans active bit, set for nonseq and seq
`define IMC_HTRANS_ACT_BIT   1

`endif

// File: imc_top_chk.sv
// imc_top_chk.sv: port assertions for imc_top
// assumes one clock hclk and async active-low hresetn
`timescale 1ns/1ps
`default_nettype none
module imc_chk #(
  parameter CM_DEPTH = 2048,
  parameter CM_AW    = 11
) (
  // clock, reset, bus answer
  input wire logic             hclk,
  input wire logic             hresetn,
  input wire logic             hreadyout,
  input wire logic             hresp,
  // pin and outputs
  input wire logic             output_drive_enable,
  input wire logic             cm_we,
  input wire logic [CM_AW-1:0] cm_addr,
  input wire logic [15:0]      cm_wdata,
  input wire logic             serial_out_oe_n,
  input wire logic [1:0]       serial_rate_sel,
  input wire logic             rate_reserved
);
  // every check on hclk, quiet in reset
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus not okay");
  a_oe_drive: assert property (output_drive_enable |=> !serial_out_oe_n)
    else $error("outputs floated");
  a_fill_low: assert property (cm_we |-> cm_wdata[10:0] == 11'h000)
    else $error("low bits set");
  a_fill_hold: assert property (cm_we && $past(cm_we) |-> $stable(cm_wdata))
    else $error("fill value moved");
  a_fill_first: assert property ($rose(cm_we) |-> cm_addr == '0)
    else $error("sweep not from zero");
  a_fill_step: assert property (cm_we && cm_addr != CM_DEPTH - 1
    |=> cm_we && cm_addr == $past(cm_addr) + 1'b1)
    else $error("sweep skipped");
  a_fill_end: assert property (cm_we && cm_addr == CM_DEPTH - 1 |=> !cm_we)
    else $error("sweep overran");
  a_rate_rsv: assert property (rate_reserved == (serial_rate_sel == 2'h3))
    else $error("reserved flag wrong");

  // main scenarios reached
  c_fill_done: cover property (cm_we && cm_addr == CM_DEPTH - 1);
  c_rate_rsv: cover property (rate_reserved);
  c_oe_float: cover property (serial_out_oe_n);
endmodule // imc_chk

bind imc_top imc_chk #(.CM_DEPTH(CM_DEPTH), .CM_AW(CM_AW)) imc_chk_inst (
  .hclk(hclk), .hresetn(hresetn), .hreadyout(hreadyout), .hresp(hresp),
  .output_drive_enable(output_drive_enable), .cm_we(cm_we), .cm_addr(cm_addr),
  .cm_wdata(cm_wdata), .serial_out_oe_n(serial_out_oe_n),
  .serial_rate_sel(serial_rate_sel), .rate_reserved(rate_reserved));
`default_nettype wire

// File: imc_top_tb.sv
// imc_top_tb.sv: self-checking bench for imc_top
// assumes imc_top and imc_top_chk compiled first
`timescale 1ns/1ps
`default_nettype none
module imc_top_tb;
  logic        hclk, hresetn, hsel, hwrite, frame_pulse, output_drive_enable;
  logic        frame_edge_seen, hreadyout, hresp, cm_we, serial_out_oe_n, rate_reserved;
  logic [1:0]  htrans, serial_rate_sel;
  logic [3:0]  cm_addr;
  logic [11:0] frame_edge_delay;
  logic [15:0] cm_wdata;
  logic [31:0] haddr, hwdata, hrdata, rd;
  int          failures, num_checks, we_cnt, i;

  // design with a 16-word connection memory
  imc_top #(.CM_DEPTH(16), .CM_AW(4)) imc_top_inst (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .frame_pulse(frame_pulse),
    .output_drive_enable(output_drive_enable), .frame_edge_seen(frame_edge_seen),
    .frame_edge_delay(frame_edge_delay), .cm_we(cm_we), .cm_addr(cm_addr),
    .cm_wdata(cm_wdata), .serial_out_oe_n(serial_out_oe_n),
    .serial_rate_sel(serial_rate_sel), .rate_reserved(rate_reserved));

  // 40 mhz clock
  initial
  begin
    hclk = 1'b0;
    forever #12.5 hclk = ~hclk;
  end

  // compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("mismatch at %0t: %h expected %h", $time, got, exp);
    end
  endtask

  // counts, verdict and end of run
  task automatic results;
    $display("%0d checks, %0d mismatches", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // bounded wait for hready at a rising edge
  task automatic wait_rdy;
    int n;
    n = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1 && n <= 50)
    begin
      n++;
      @(posedge hclk);
    end
    if (n > 50)
      failures++;
    if (n > 50)
      results;
  endtask

  // one single transfer, read data lands in rd
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
    hsel   <= 1'b1;
    haddr  <= a;
    hwrite <= w;
    htrans <= 2'h2;
    wait_rdy;
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy;
    rd = hrdata;
  endtask

  // n frames of 40 cycles, pulse at each end
  task automatic frames(input int n);
    repeat (n)
    begin
      repeat (39) @(posedge hclk);
      frame_pulse <= 1'b1;
      @(posedge hclk);
      frame_pulse <= 1'b0;
    end
  endtask

  // judge every connection memory write
  always @(posedge hclk)
    if (cm_we === 1'b1)
    begin
      we_cnt++;
      chk(cm_wdata, 32'ha800);
    end

  // read back, each rate, standby, unmapped place
  task automatic t_regs;
    xfer(0, 32'h0, 32'h0);
    chk(rd, 32'h0);
    for (i = 0; i < 4; i++)
    begin
      xfer(1, 32'h0, 32'h8 | i);
      xfer(0, 32'h0, 32'h0);
      chk(rd, 32'h8 | i);
      chk({serial_out_oe_n, serial_rate_sel}, i);
      chk(rate_reserved, i == 3);
    end
    xfer(1, 32'h0, 32'h0);
    xfer(1, 32'h10, 32'hffff);
    xfer(0, 32'h10, 32'h0);
    chk(rd, 32'h0);
    chk(serial_out_oe_n, 1'b1);
    output_drive_enable <= 1'b1;
    xfer(0, 32'h0, 32'h0);
    chk(rd, 32'h0);
    chk(serial_out_oe_n, 1'b0);
    $display("regs done");
  endtask

  // fill, refused, late allow, two kinds of abort
  task automatic t_fill;
    for (i = 0; i < 4; i++)
    begin
      xfer(1, 32'h0, 32'h2a0);
      xfer(1, 32'h4, i != 1);
      xfer(1, 32'h0, 32'h2b0);
      if (i > 0)
        xfer(1, i == 3 ? 32'h0 : 32'h4, i == 1 ? 32'h1 : i == 3 ? 32'h2a0 : 32'h0);
      we_cnt = 0;
      frames(2);
      chk(we_cnt, i == 0 ? 16 : 0);
      xfer(0, 32'h0, 32'h0);
      chk(rd, i == 1 ? 32'h2b0 : 32'h2a0);
    end
    $display("fill done");
  endtask

  // two evaluations, late edge ignored, clear on fall
  task automatic t_measure;
    for (i = 0; i < 2; i++)
    begin
      xfer(1, 32'h0, 32'h4);
      repeat (2) @(posedge hclk);
      frame_edge_delay <= 12'h5a3 - i;
      frame_edge_seen  <= 1'b1;
      @(posedge hclk);
      frame_edge_delay <= 12'h0f0;
      @(posedge hclk);
      frame_edge_seen  <= 1'b0;
      xfer(0, 32'hc, 32'h0);
      chk(rd, 32'h15a3 - i);
      xfer(1, 32'h0, 32'h0);
      @(posedge hclk);
      xfer(0, 32'hc, 32'h0);
      chk(rd, 32'h0);
      frames(1);
    end
    $display("measure done");
  endtask

  // reset, scenarios, verdict
  initial
  begin
    {hresetn, hsel, hwrite, frame_pulse, output_drive_enable, frame_edge_seen} = 6'h0;
    htrans = 2'h0;
    haddr = 32'h0;
    hwdata = 32'h0;
    frame_edge_delay = 12'h000;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    t_regs;
    t_fill;
    t_measure;
    results;
  end
endmodule // imc_top_tb
`default_nettype wire
